// >>> shared/tss_pkg.sv
package tss_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MS_RDI_CTRL = 8'h1a;
  localparam logic [7:0] ADDR_OP_ONE      = 8'h30;
  localparam logic [7:0] ADDR_SRC_ONE     = 8'h60;
  localparam logic [7:0] ADDR_SRC_TWO     = 8'h61;
  localparam logic [7:0] ADDR_SRC_THREE   = 8'h62;
  localparam logic [7:0] ADDR_SRC_FOUR    = 8'h63;
  localparam logic [7:0] ADDR_STATUS      = 8'h64;

  // ----------------------------------------------------------------
  // Writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_MS_RDI_CTRL = 8'h06;
  localparam logic [7:0] MASK_OP_ONE      = 8'h70;
  localparam logic [7:0] MASK_SRC_FOUR    = 8'h60;
  localparam logic [7:0] RESET_REG        = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RDI_FORCE_BIT       = 1;
  localparam int RDI_EXCESS_BIT      = 2;
  localparam int REI_SRC_BIT         = 6;
  localparam int NU1_DEF_BIT         = 5;
  localparam int RDI_SRC_BIT         = 4;
  localparam int J0_SRC_LSB          = 6;
  localparam int E1_SRC_BIT          = 5;
  localparam int F1_SRC_BIT          = 4;
  localparam int RDCC_SRC_BIT        = 3;
  localparam int MDCC_SRC_BIT        = 2;
  localparam int E2_SRC_BIT          = 1;
  localparam int M1_SRC_BIT          = 0;
  localparam int NU99_SRC_BIT        = 7;
  localparam int NU98_SRC_BIT        = 6;
  localparam int UN39_SRC_BIT        = 5;
  localparam int UN38_SRC_BIT        = 4;
  localparam int UN36_SRC_BIT        = 3;
  localparam int S1_SRC_BIT          = 2;
  localparam int K2_SRC_BIT          = 1;
  localparam int K1_SRC_BIT          = 0;
  localparam int NU29_SRC_LSB        = 6;
  localparam int NU28_SRC_LSB        = 4;
  localparam int NU19_SRC_LSB        = 2;
  localparam int NU18_SRC_LSB        = 0;
  localparam int MD35_SRC_BIT        = 6;
  localparam int MD33_SRC_BIT        = 5;

  // ----------------------------------------------------------------
  // Byte values
  // ----------------------------------------------------------------
  localparam logic [2:0] MS_RDI_CODE     = 3'h6;
  localparam logic [7:0] NU1_DEFAULT     = 8'haa;

  // ----------------------------------------------------------------
  // Overhead byte slots
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SLOT_OTHER = 5'h00,
    SLOT_J0    = 5'h01,
    SLOT_E1    = 5'h02,
    SLOT_F1    = 5'h03,
    SLOT_D1D3  = 5'h04,
    SLOT_D4D12 = 5'h05,
    SLOT_E2    = 5'h06,
    SLOT_M1    = 5'h07,
    SLOT_NU99  = 5'h08,
    SLOT_NU98  = 5'h09,
    SLOT_UN39  = 5'h0a,
    SLOT_UN38  = 5'h0b,
    SLOT_UN36  = 5'h0c,
    SLOT_S1    = 5'h0d,
    SLOT_K2    = 5'h0e,
    SLOT_K1    = 5'h0f,
    SLOT_NU29  = 5'h10,
    SLOT_NU28  = 5'h11,
    SLOT_NU19  = 5'h12,
    SLOT_NU18  = 5'h13,
    SLOT_MD35  = 5'h14,
    SLOT_MD33  = 5'h15
  } tss_slot_t;

  // Configuration set applied to the outgoing frame
  typedef struct packed {
    logic [7:0] ms_rdi_ctrl;
    logic [7:0] op_one;
    logic [7:0] src_one;
    logic [7:0] src_two;
    logic [7:0] src_three;
    logic [7:0] src_four;
  } tss_cfg_t;

  // Candidate sources for one outgoing byte
  typedef struct packed {
    logic [7:0] up_value;
    logic [7:0] serial_oh;
    logic [7:0] row_ow;
    logic [7:0] user_ch;
    logic [7:0] regen_dcc;
    logic [7:0] mux_dcc;
    logic [7:0] mux_ow;
    logic [7:0] received;
    logic [7:0] rei_value;
    logic [2:0] hw_rdi;
  } tss_src_t;

endpackage : tss_pkg

// >>> logic/tss_source_select.sv
// Functional notes
// (R1) K2 RDI controls act only with K2 and RDI both hardware sourced.
// (R2) Excess-B2 enable plus active excess state inserts 110 in K2 low bits.
// (R3) Force control inserts 110 in K2 low bits whenever RDI insertion is armed (R1) and regenerator mode is off.
// (R4) J0: 00 microprocessor, 01 serial overhead, 1X received byte.
// (R5) E1: 0 row orderwire input, 1 received byte.
// (R6) F1: 0 user channel input, 1 received byte.
// (R7) D1-D3: 0 regenerator data channel input, 1 received bytes.
// (R8) D4-D12: 0 multiplex data channel input, 1 received bytes.
// (R9) E2: 0 multiplex orderwire input, 1 received byte.
// (R10) M1: 0 hardware REI, 1 serial; regenerator passes received M1.
// (R11) STM-1 row 9 national bytes: 0 microprocessor, 1 serial; regen passes.
// (R12) STM-1 row 3 unused bytes: 0 serial, 1 received byte.
// (R13) S1: 0 microprocessor, 1 serial; regenerator passes received S1.
// (R14) K2: 0 hardware process, 1 serial; regenerator passes received K2.
// (R15) K1: 0 microprocessor, 1 serial; regenerator passes received K1.
// (R16) STM-1 row 2 national bytes: 00 microprocessor, 01 serial, 1X received.
// (R17) STM-1 row 1 national bytes: 00 default rule, 01 serial, 1X received.
// (R18) STM-1 row 3 media bytes: 0 serial, 1 received byte.
// (R19) Row 1 national default: enable 0 sends AAH, 1 sends microprocessor value.
// (R20) Hardware M1: REI source 0 uses B2 feedback, 1 sends zero.
// (R21) Hardware K2: RDI source 0 inserts hardware RDI, 1 all register bits.
// (R22) Selector changes take effect at a frame boundary only.
module tss_source_select (
  input  wire logic             SYS_CLK,
  input  wire logic             RST,
  input  wire logic [7:0]       REG_ADDR,
  input  wire logic [7:0]       REG_WDATA,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  output logic      [7:0]       REG_RDATA,
  input  wire logic             REGEN_MODE,
  input  wire logic             STM1_MODE,
  input  wire logic             EXCESS_B2_ERROR_STATE,
  input  wire logic             FRAME_START,
  input  wire logic             SLOT_VALID,
  input  wire tss_pkg::tss_slot_t SLOT_ID,
  input  wire tss_pkg::tss_src_t  SLOT_SRC,
  output logic                  TX_VALID,
  output tss_pkg::tss_slot_t    TX_SLOT,
  output logic      [7:0]       TX_BYTE
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software writes land in the pending set; the active set copies it
  // on FRAME_START so a byte never mixes two selector settings.
  tss_pkg::tss_cfg_t pend;
  tss_pkg::tss_cfg_t act;
  tss_pkg::tss_cfg_t next_pend;
  tss_pkg::tss_cfg_t next_act;

  wire wr_rdi   = REG_WR && (REG_ADDR == tss_pkg::ADDR_MS_RDI_CTRL);
  wire wr_op    = REG_WR && (REG_ADDR == tss_pkg::ADDR_OP_ONE);
  wire wr_one   = REG_WR && (REG_ADDR == tss_pkg::ADDR_SRC_ONE);
  wire wr_two   = REG_WR && (REG_ADDR == tss_pkg::ADDR_SRC_TWO);
  wire wr_three = REG_WR && (REG_ADDR == tss_pkg::ADDR_SRC_THREE);
  wire wr_four  = REG_WR && (REG_ADDR == tss_pkg::ADDR_SRC_FOUR);

  assign next_pend.ms_rdi_ctrl = wr_rdi ? (REG_WDATA & tss_pkg::MASK_MS_RDI_CTRL)
                                        : pend.ms_rdi_ctrl;
  assign next_pend.op_one      = wr_op ? (REG_WDATA & tss_pkg::MASK_OP_ONE)
                                       : pend.op_one;
  assign next_pend.src_one     = wr_one ? REG_WDATA : pend.src_one;
  assign next_pend.src_two     = wr_two ? REG_WDATA : pend.src_two;
  assign next_pend.src_three   = wr_three ? REG_WDATA : pend.src_three;
  assign next_pend.src_four    = wr_four ? (REG_WDATA & tss_pkg::MASK_SRC_FOUR)
                                         : pend.src_four;

  // A write in the frame-start cycle is taken into the new frame
  assign next_act = FRAME_START ? next_pend : act; // R22

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic rdi_inserted;
  wire [7:0] status_word = {6'h00, rdi_inserted, EXCESS_B2_ERROR_STATE};
  logic [7:0] read_mux;

  always_comb begin
    case (REG_ADDR)
      tss_pkg::ADDR_MS_RDI_CTRL: read_mux = pend.ms_rdi_ctrl;
      tss_pkg::ADDR_OP_ONE:      read_mux = pend.op_one;
      tss_pkg::ADDR_SRC_ONE:     read_mux = pend.src_one;
      tss_pkg::ADDR_SRC_TWO:     read_mux = pend.src_two;
      tss_pkg::ADDR_SRC_THREE:   read_mux = pend.src_three;
      tss_pkg::ADDR_SRC_FOUR:    read_mux = pend.src_four;
      tss_pkg::ADDR_STATUS:      read_mux = status_word;
      default:                   read_mux = 8'h00;
    endcase
  end

  wire [7:0] next_rdata = REG_RD ? read_mux : 8'h00;

  // ----------------------------------------------------------------
  // Field decode of the active set
  // ----------------------------------------------------------------
  wire       rdi_force    = act.ms_rdi_ctrl[tss_pkg::RDI_FORCE_BIT];
  wire       rdi_excess   = act.ms_rdi_ctrl[tss_pkg::RDI_EXCESS_BIT];
  wire       rei_source_select = act.op_one[tss_pkg::REI_SRC_BIT];
  wire       natuse_row1_default_enable = act.op_one[tss_pkg::NU1_DEF_BIT];
  wire       rdi_source_select = act.op_one[tss_pkg::RDI_SRC_BIT];
  wire [1:0] j0_source_select  = act.src_one[tss_pkg::J0_SRC_LSB +: 2];
  wire       e1_source_select  = act.src_one[tss_pkg::E1_SRC_BIT];
  wire       f1_source_select  = act.src_one[tss_pkg::F1_SRC_BIT];
  wire       regen_dcc_source_select = act.src_one[tss_pkg::RDCC_SRC_BIT];
  wire       mux_dcc_source_select   = act.src_one[tss_pkg::MDCC_SRC_BIT];
  wire       e2_source_select  = act.src_one[tss_pkg::E2_SRC_BIT];
  wire       m1_source_select  = act.src_one[tss_pkg::M1_SRC_BIT];
  wire       natuse_r9c9_source = act.src_two[tss_pkg::NU99_SRC_BIT];
  wire       natuse_r9c8_source = act.src_two[tss_pkg::NU98_SRC_BIT];
  wire       unused_r3c9_source = act.src_two[tss_pkg::UN39_SRC_BIT];
  wire       unused_r3c8_source = act.src_two[tss_pkg::UN38_SRC_BIT];
  wire       unused_r3c6_source = act.src_two[tss_pkg::UN36_SRC_BIT];
  wire       s1_source_select  = act.src_two[tss_pkg::S1_SRC_BIT];
  wire       k2_source_select  = act.src_two[tss_pkg::K2_SRC_BIT];
  wire       k1_source_select  = act.src_two[tss_pkg::K1_SRC_BIT];
  wire [1:0] natuse_r2c9_source = act.src_three[tss_pkg::NU29_SRC_LSB +: 2];
  wire [1:0] natuse_r2c8_source = act.src_three[tss_pkg::NU28_SRC_LSB +: 2];
  wire [1:0] natuse_r1c9_source = act.src_three[tss_pkg::NU19_SRC_LSB +: 2];
  wire [1:0] natuse_r1c8_source = act.src_three[tss_pkg::NU18_SRC_LSB +: 2];
  wire       media_r3c5_source = act.src_four[tss_pkg::MD35_SRC_BIT];
  wire       media_r3c3_source = act.src_four[tss_pkg::MD33_SRC_BIT];

  // ----------------------------------------------------------------
  // Hardware-generated bytes
  // ----------------------------------------------------------------
  wire [7:0] m1_hw = rei_source_select ? 8'h00 : SLOT_SRC.rei_value; // R20

  // RDI insertion is armed only when K2 and its RDI bits come from hardware
  wire rdi_armed = !k2_source_select && !rdi_source_select; // R1
  wire rdi_by_excess = rdi_excess && EXCESS_B2_ERROR_STATE; // R2
  wire rdi_insert = rdi_armed && (rdi_force || rdi_by_excess); // R3
  wire [2:0] hw_rdi_bits = rdi_insert ? tss_pkg::MS_RDI_CODE : SLOT_SRC.hw_rdi;
  // Upper bits of the hardware K2 byte always follow the microprocessor register value
  wire [7:0] k2_hw = rdi_source_select ? SLOT_SRC.up_value
                                       : {SLOT_SRC.up_value[7:3], hw_rdi_bits}; // R21

  wire [7:0] nu1_up = natuse_row1_default_enable ? SLOT_SRC.up_value
                                                 : tss_pkg::NU1_DEFAULT; // R19

  // ----------------------------------------------------------------
  // Per-slot selection helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick3(input logic [1:0] sel, input logic [7:0] a,
                                       input logic [7:0] b, input logic [7:0] c);
    pick3 = sel[1] ? c : (sel[0] ? b : a);
  endfunction

  wire [7:0] rx  = SLOT_SRC.received;
  wire [7:0] soh = SLOT_SRC.serial_oh;
  wire [7:0] up  = SLOT_SRC.up_value;

  wire [7:0] j0_byte   = pick3(j0_source_select, up, soh, rx); // R4
  wire [7:0] e1_byte   = e1_source_select ? rx : SLOT_SRC.row_ow; // R5
  wire [7:0] f1_byte   = f1_source_select ? rx : SLOT_SRC.user_ch; // R6
  wire [7:0] rdcc_byte = regen_dcc_source_select ? rx : SLOT_SRC.regen_dcc; // R7
  wire [7:0] mdcc_byte = mux_dcc_source_select ? rx : SLOT_SRC.mux_dcc; // R8
  wire [7:0] e2_byte   = e2_source_select ? rx : SLOT_SRC.mux_ow; // R9
  wire [7:0] m1_byte   = REGEN_MODE ? rx : (m1_source_select ? soh : m1_hw); // R10
  wire [7:0] nu99_byte = REGEN_MODE ? rx : (natuse_r9c9_source ? soh : up); // R11
  wire [7:0] nu98_byte = REGEN_MODE ? rx : (natuse_r9c8_source ? soh : up); // R11
  wire [7:0] un39_byte = unused_r3c9_source ? rx : soh; // R12
  wire [7:0] un38_byte = unused_r3c8_source ? rx : soh; // R12
  wire [7:0] un36_byte = unused_r3c6_source ? rx : soh; // R12
  wire [7:0] s1_byte   = REGEN_MODE ? rx : (s1_source_select ? soh : up); // R13
  wire [7:0] k2_byte   = REGEN_MODE ? rx : (k2_source_select ? soh : k2_hw); // R14
  wire [7:0] k1_byte   = REGEN_MODE ? rx : (k1_source_select ? soh : up); // R15
  wire [7:0] nu29_byte = pick3(natuse_r2c9_source, up, soh, rx); // R16
  wire [7:0] nu28_byte = pick3(natuse_r2c8_source, up, soh, rx); // R16
  wire [7:0] nu19_byte = pick3(natuse_r1c9_source, nu1_up, soh, rx); // R17
  wire [7:0] nu18_byte = pick3(natuse_r1c8_source, nu1_up, soh, rx); // R17
  wire [7:0] md35_byte = media_r3c5_source ? rx : soh; // R18
  wire [7:0] md33_byte = media_r3c3_source ? rx : soh; // R18

  // ----------------------------------------------------------------
  // Slot multiplexer
  // ----------------------------------------------------------------
  // STM-1-only slots fall back to the received byte in STM-0 mode,
  // so stray slot tags cannot inject configured data.
  logic [7:0] sel_byte;
  logic [7:0] stm1_byte;
  logic       stm1_only;

  always_comb begin
    stm1_only = 1'b1;
    case (SLOT_ID)
      tss_pkg::SLOT_NU99: stm1_byte = nu99_byte;
      tss_pkg::SLOT_NU98: stm1_byte = nu98_byte;
      tss_pkg::SLOT_UN39: stm1_byte = un39_byte;
      tss_pkg::SLOT_UN38: stm1_byte = un38_byte;
      tss_pkg::SLOT_UN36: stm1_byte = un36_byte;
      tss_pkg::SLOT_NU29: stm1_byte = nu29_byte;
      tss_pkg::SLOT_NU28: stm1_byte = nu28_byte;
      tss_pkg::SLOT_NU19: stm1_byte = nu19_byte;
      tss_pkg::SLOT_NU18: stm1_byte = nu18_byte;
      tss_pkg::SLOT_MD35: stm1_byte = md35_byte;
      tss_pkg::SLOT_MD33: stm1_byte = md33_byte;
      default: begin
        stm1_byte = rx;
        stm1_only = 1'b0;
      end
    endcase
  end

  always_comb begin
    case (SLOT_ID)
      tss_pkg::SLOT_J0:    sel_byte = j0_byte;
      tss_pkg::SLOT_E1:    sel_byte = e1_byte;
      tss_pkg::SLOT_F1:    sel_byte = f1_byte;
      tss_pkg::SLOT_D1D3:  sel_byte = rdcc_byte;
      tss_pkg::SLOT_D4D12: sel_byte = mdcc_byte;
      tss_pkg::SLOT_E2:    sel_byte = e2_byte;
      tss_pkg::SLOT_M1:    sel_byte = m1_byte;
      tss_pkg::SLOT_S1:    sel_byte = s1_byte;
      tss_pkg::SLOT_K2:    sel_byte = k2_byte;
      tss_pkg::SLOT_K1:    sel_byte = k1_byte;
      default:             sel_byte = (stm1_only && STM1_MODE) ? stm1_byte : rx;
    endcase
  end

  wire next_rdi_inserted = (SLOT_VALID && SLOT_ID == tss_pkg::SLOT_K2 && !REGEN_MODE)
                           ? rdi_insert : rdi_inserted;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pend         <= '0;
      act          <= '0;
      REG_RDATA    <= tss_pkg::RESET_REG;
      TX_VALID     <= 1'b0;
      TX_SLOT      <= tss_pkg::SLOT_OTHER;
      TX_BYTE      <= 8'h00;
      rdi_inserted <= 1'b0;
    end else begin
      pend         <= next_pend;
      act          <= next_act;
      REG_RDATA    <= next_rdata;
      TX_VALID     <= SLOT_VALID;
      TX_SLOT      <= SLOT_ID;
      TX_BYTE      <= SLOT_VALID ? sel_byte : 8'h00;
      rdi_inserted <= next_rdi_inserted;
    end
  end

endmodule // tss_source_select

// >>> bench/tss_source_select_chk.sv
module tss_source_select_chk (
  input wire logic               SYS_CLK,
  input wire logic               RST,
  input wire logic [7:0]         REG_ADDR,
  input wire logic [7:0]         REG_WDATA,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic [7:0]         REG_RDATA,
  input wire logic               REGEN_MODE,
  input wire logic               STM1_MODE,
  input wire logic               EXCESS_B2_ERROR_STATE,
  input wire logic               SLOT_VALID,
  input wire tss_pkg::tss_slot_t SLOT_ID,
  input wire tss_pkg::tss_src_t  SLOT_SRC,
  input wire logic               TX_VALID,
  input wire tss_pkg::tss_slot_t TX_SLOT,
  input wire logic [7:0]         TX_BYTE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // Slots the regenerator passes through, and slots that exist only in STM-1
  wire logic regen_slot = SLOT_ID inside {tss_pkg::SLOT_M1, tss_pkg::SLOT_K1, tss_pkg::SLOT_K2,
                                          tss_pkg::SLOT_S1, tss_pkg::SLOT_NU99, tss_pkg::SLOT_NU98};
  wire logic stm1_slot  = (SLOT_ID >= tss_pkg::SLOT_NU99 && SLOT_ID <= tss_pkg::SLOT_UN36) ||
                          SLOT_ID >= tss_pkg::SLOT_NU29;
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  sequence s_wr_rd;
    REG_WR && REG_ADDR == 8'h60 ##1 REG_RD && REG_ADDR == 8'h60;
  endsequence
  property p_rd_only;
    REG_RDATA != 8'h00 |-> $past(REG_RD);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read slot");
  property p_readback;
    s_wr_rd |=> REG_RDATA == $past(REG_WDATA, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("pending value not read back");
  property p_rsv_rdi;
    REG_RD && REG_ADDR == 8'h1a |=> REG_RDATA[7:3] == 5'h00 && !REG_RDATA[0];
  endproperty
  a_rsv_rdi: assert property (p_rsv_rdi) else $error("reserved bits set at 1a");
  property p_rsv_four;
    REG_RD && REG_ADDR == 8'h63 |=> !REG_RDATA[7] && REG_RDATA[4:0] == 5'h00;
  endproperty
  a_rsv_four: assert property (p_rsv_four) else $error("reserved bits set at 63");
  property p_status;
    REG_RD && REG_ADDR == 8'h64 |=> REG_RDATA[0] == $past(EXCESS_B2_ERROR_STATE);
  endproperty
  a_status: assert property (p_status) else $error("status bit 0 stale");
  // ----------------------------------------------------------------
  // Byte stream
  // ----------------------------------------------------------------
  property p_echo;
    SLOT_VALID |=> TX_VALID && TX_SLOT == $past(SLOT_ID);
  endproperty
  a_echo: assert property (p_echo) else $error("slot not echoed");
  property p_idle;
    !SLOT_VALID |=> !TX_VALID && TX_BYTE == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("byte sent without slot");
  property p_regen;
    SLOT_VALID && REGEN_MODE && regen_slot |=> TX_BYTE == $past(SLOT_SRC.received);
  endproperty
  a_regen: assert property (p_regen) else $error("regenerator did not pass");
  property p_stm0;
    SLOT_VALID && !STM1_MODE && stm1_slot |=> TX_BYTE == $past(SLOT_SRC.received);
  endproperty
  a_stm0: assert property (p_stm0) else $error("STM-1 slot used in STM-0");
endmodule // tss_source_select_chk

bind tss_source_select tss_source_select_chk chk (.*);

// >>> bench/tss_line_model.sv
module tss_line_model (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        SLOT_VALID,
  output tss_pkg::tss_src_t SLOT_SRC
);
  logic [7:0] cnt;
  always_ff @(posedge SYS_CLK) begin
    if (RST)
      cnt <= 8'h00;
    else if (SLOT_VALID)
      cnt <= cnt + 8'h01;
  end
  // Every source differs from every other in each slot, so a wrong pick shows
  assign SLOT_SRC = '{up_value: cnt ^ 8'h11, serial_oh: cnt ^ 8'h22, row_ow: cnt ^ 8'h33,
                      user_ch: cnt ^ 8'h44, regen_dcc: cnt ^ 8'h55, mux_dcc: cnt ^ 8'h66,
                      mux_ow: cnt ^ 8'h77, received: cnt ^ 8'h88, rei_value: cnt ^ 8'h99,
                      hw_rdi: cnt[2:0]};
endmodule // tss_line_model

// >>> bench/tb_tss_source_select.sv
module tb_tss_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, FRAME_START = 1'b0;
  logic REGEN_MODE = 1'b0, STM1_MODE = 1'b0, EXCESS_B2_ERROR_STATE = 1'b0, SLOT_VALID = 1'b0;
  logic TX_VALID;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA, TX_BYTE, v;
  tss_pkg::tss_slot_t SLOT_ID = tss_pkg::SLOT_OTHER, TX_SLOT;
  tss_pkg::tss_src_t  SLOT_SRC;
  int n_mismatch = 0, num_checks = 0;
  localparam logic [7:0] ADR [6] = '{8'h1a, 8'h30, 8'h60, 8'h61, 8'h62, 8'h63};
  localparam logic [7:0] MSK [6] = '{8'h06, 8'h70, 8'hff, 8'hff, 8'hff, 8'h60};
  localparam logic [7:0] CFG [5][6] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h06, 8'h70, 8'h55, 8'h55, 8'h55, 8'h20}, '{8'hff, 8'h8f, 8'haa, 8'haa, 8'haa, 8'hff},
    '{8'h02, 8'h20, 8'hff, 8'h01, 8'h00, 8'h60}, '{8'h04, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h00}};
  logic [7:0] pend [6] = '{default: 8'h00};
  logic [7:0] act [6]  = '{default: 8'h00};

  always #2.5 SYS_CLK = ~SYS_CLK;
  tss_source_select dut (.*);
  tss_line_model line (.SYS_CLK(SYS_CLK), .RST(RST), .SLOT_VALID(SLOT_VALID), .SLOT_SRC(SLOT_SRC));

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  function automatic logic [7:0] two(logic [1:0] q, logic [7:0] a, b, c);
    return q[1] ? c : (q[0] ? b : a);
  endfunction
  function automatic logic [7:0] exp_b(tss_pkg::tss_slot_t id, tss_pkg::tss_src_t s,
                                       logic rg, st, ex);
    logic [7:0] r;
    logic [2:0] rdi;
    rdi = (act[0][1] | (act[0][2] & ex)) ? 3'h6 : s.hw_rdi;
    case (id)
      tss_pkg::SLOT_J0:    r = two(act[2][7:6], s.up_value, s.serial_oh, s.received);
      tss_pkg::SLOT_E1:    r = act[2][5] ? s.received : s.row_ow;
      tss_pkg::SLOT_F1:    r = act[2][4] ? s.received : s.user_ch;
      tss_pkg::SLOT_D1D3:  r = act[2][3] ? s.received : s.regen_dcc;
      tss_pkg::SLOT_D4D12: r = act[2][2] ? s.received : s.mux_dcc;
      tss_pkg::SLOT_E2:    r = act[2][1] ? s.received : s.mux_ow;
      tss_pkg::SLOT_M1:    r = act[2][0] ? s.serial_oh : (act[1][6] ? 8'h00 : s.rei_value);
      tss_pkg::SLOT_NU99:  r = act[3][7] ? s.serial_oh : s.up_value;
      tss_pkg::SLOT_NU98:  r = act[3][6] ? s.serial_oh : s.up_value;
      tss_pkg::SLOT_UN39:  r = act[3][5] ? s.received : s.serial_oh;
      tss_pkg::SLOT_UN38:  r = act[3][4] ? s.received : s.serial_oh;
      tss_pkg::SLOT_UN36:  r = act[3][3] ? s.received : s.serial_oh;
      tss_pkg::SLOT_S1:    r = act[3][2] ? s.serial_oh : s.up_value;
      tss_pkg::SLOT_K2:    r = act[3][1] ? s.serial_oh :
                               (act[1][4] ? s.up_value : {s.up_value[7:3], rdi});
      tss_pkg::SLOT_K1:    r = act[3][0] ? s.serial_oh : s.up_value;
      tss_pkg::SLOT_NU29:  r = two(act[4][7:6], s.up_value, s.serial_oh, s.received);
      tss_pkg::SLOT_NU28:  r = two(act[4][5:4], s.up_value, s.serial_oh, s.received);
      tss_pkg::SLOT_NU19:  r = two(act[4][3:2], act[1][5] ? s.up_value : 8'haa, s.serial_oh,
                                   s.received);
      tss_pkg::SLOT_NU18:  r = two(act[4][1:0], act[1][5] ? s.up_value : 8'haa, s.serial_oh,
                                   s.received);
      tss_pkg::SLOT_MD35:  r = act[5][6] ? s.received : s.serial_oh;
      tss_pkg::SLOT_MD33:  r = act[5][5] ? s.received : s.serial_oh;
      default:             r = s.received;
    endcase
    if (rg && id inside {tss_pkg::SLOT_M1, tss_pkg::SLOT_K1, tss_pkg::SLOT_K2, tss_pkg::SLOT_S1,
                         tss_pkg::SLOT_NU99, tss_pkg::SLOT_NU98})
      r = s.received;
    if (!st && ((id >= tss_pkg::SLOT_NU99 && id <= tss_pkg::SLOT_UN36) || id >= tss_pkg::SLOT_NU29))
      r = s.received;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= a;
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    wr_raw(ADR[i], d);
    pend[i] = d & MSK[i];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD   <= 1'b0;
    #1;
    v = REG_RDATA;
  endtask
  // Write then read back with no gap between the strobes
  task automatic wr_rd(input int i, input logic [7:0] d);
    @(posedge SYS_CLK);
    REG_ADDR  <= ADR[i];
    REG_WDATA <= d;
    REG_WR    <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR    <= 1'b0;
    REG_RD    <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD    <= 1'b0;
    #1;
    v = REG_RDATA;
    pend[i] = d & MSK[i];
  endtask
  task automatic frame();
    @(posedge SYS_CLK);
    FRAME_START <= 1'b1;
    @(posedge SYS_CLK);
    FRAME_START <= 1'b0;
    act = pend;
  endtask
  task automatic slot(input tss_pkg::tss_slot_t id);
    logic [7:0] e;
    @(posedge SYS_CLK);
    SLOT_VALID <= 1'b1;
    SLOT_ID    <= id;
    #1;
    e = exp_b(id, SLOT_SRC, REGEN_MODE, STM1_MODE, EXCESS_B2_ERROR_STATE);
    @(posedge SYS_CLK);
    SLOT_VALID <= 1'b0;
    #1;
    cmp(TX_BYTE, e);
    cmp(8'(TX_SLOT), 8'(id));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    wr_raw(8'h05, 8'hff);
    rd(8'h00);
    cmp(v, 8'h00);
    wr_rd(2, 8'h3c);
    cmp(v, 8'h3c);
    for (int c = 0; c < 5; c++) begin
      for (int i = 0; i < 6; i++) wr(i, CFG[c][i]);
      for (int i = 0; i < 6; i++) begin
        rd(ADR[i]);
        cmp(v, pend[i]);
      end
      // Fresh settings must not reach the line before the frame boundary;
      // regenerator mode would hide the K2 source, so it is left off here
      @(posedge SYS_CLK);
      REGEN_MODE <= 1'b0;
      slot(tss_pkg::SLOT_K2);
      slot(tss_pkg::SLOT_J0);
      frame();
      for (int m = 0; m < 8; m++) begin
        @(posedge SYS_CLK);
        REGEN_MODE            <= m[0];
        STM1_MODE             <= m[1];
        EXCESS_B2_ERROR_STATE <= m[2];
        for (int k = 0; k < 22; k++) slot(tss_pkg::tss_slot_t'(k));
      end
    end
    rd(8'h64);
    cmp(v, 8'h03);
    report_and_stop();
  end
endmodule // tb_tss_source_select
